// File: rtl/status_bank_regs.vh
// constants of the receiver status read-back bank
// assumes: included by the bank module only
`ifndef STATUS_BANK_REGS_VH
`define STATUS_BANK_REGS_VH

// control addresses
`define ADDR_DETECT_EVENTS   8'hEA
`define ADDR_PORT_RATE       8'hEB
`define ADDR_TX_CS_REMOVED   8'hE9
`define ADDR_LEGACY_A        8'hEC
`define ADDR_LEGACY_B        8'hED
`define ADDR_IRQ_SELECT      8'h08

// field positions, first word
`define POS_DETECT           0
`define POS_EVENTS           8
`define POS_STREAM           16
`define POS_FRAME_LEN        20
// field positions, second word
`define POS_PORT_LEVEL       0
`define POS_RATE_CODE        4

// reset values
`define RST_IRQ_SELECT       8'h00
`define RST_LEGACY           24'h000000
`define RST_WORD             24'h000000

`endif

// File: rtl/receiver_status_readback.v
// receiver status read-back bank: two status words, event latches, strap
// assumes: serial control front end gives decoded read/write strobes on clk
// Functional notes
// - word one bits 8-15 latched event flags
// - word one bits 16-19 stream indicators
// - word one bits 20-23 read zero
// - word two bits 0-3 port input levels
// - word two bits 4-7 computed rate code
// - word two bits 8-15 no measured value
// - address E9 writes have no effect
// - addresses EC, ED keep predecessor function
// - pull-down strap: ports in, through out
// - pull-up strap: ports out, through out
// - interrupt is a level only
`timescale 1ns/1ps
`default_nettype none
`include "status_bank_regs.vh"

module receiver_status_readback (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // control access
  input  wire [7:0]  addr,
  input  wire        wr_stb,
  input  wire [23:0] wr_data,
  input  wire        rd_stb,
  output reg  [23:0] rd_data_q,
  output reg         rd_valid_q,
  // receiver status
  input  wire [6:0]  input_present_flag,
  input  wire [7:0]  event_pulse,
  input  wire [3:0]  stream_status,
  input  wire [3:0]  computed_rate_code,
  // pins
  input  wire        irq_pin_in,
  output reg         irq_n_q,
  output reg         irq_oe_q,
  input  wire [3:0]  aux_port_pin_in,
  output reg  [3:0]  aux_port_pin_oe_q,
  output reg         aux_rx_through_oe_q
);

  //////////////////////////////////////////////////////////////////////////////
  // synchronisers: two flops per pin bit; only the second feeds the logic
  // pin order in the bus: detect flags, port levels, strap
  wire [11:0] pin_raw;
  wire [11:0] pin_sync;
  wire [6:0]  det_sync;
  wire [3:0]  port_sync;
  wire        strap_sync;

  assign pin_raw = {irq_pin_in, aux_port_pin_in, input_present_flag};

  genvar si;
  generate
    for (si = 0; si < 12; si = si + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      always @(posedge clk) begin
        s1_q <= pin_raw[si];
        s2_q <= s1_q;
      end
      assign pin_sync[si] = s2_q;
    end
  endgenerate

  assign det_sync   = pin_sync[6:0];
  assign port_sync  = pin_sync[10:7];
  assign strap_sync = pin_sync[11];

  //////////////////////////////////////////////////////////////////////////////
  // strap capture: pin is released during reset so the pull resistor decides
  // pull-down: port pins stay inputs; pull-up: they become outputs
  // the through output is driven in both cases
  reg strap_pullup_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      strap_pullup_q      <= strap_sync;
      aux_port_pin_oe_q   <= 4'h0;
      aux_rx_through_oe_q <= 1'b0;
    end else begin
      // strap frozen until the next reset; later pin changes are ignored
      aux_port_pin_oe_q   <= {4{strap_pullup_q}};
      aux_rx_through_oe_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the write and read paths
  function addr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      addr_hit = (a == target);
    end
  endfunction

  // read strobes
  wire        rd_events     = rd_stb && addr_hit(addr, `ADDR_DETECT_EVENTS);
  wire        rd_port_rate  = rd_stb && addr_hit(addr, `ADDR_PORT_RATE);
  wire        rd_legacy_a   = rd_stb && addr_hit(addr, `ADDR_LEGACY_A);
  wire        rd_legacy_b   = rd_stb && addr_hit(addr, `ADDR_LEGACY_B);
  // write strobes; the retired transmitter address has none on purpose
  wire        wr_irq_select = wr_stb && addr_hit(addr, `ADDR_IRQ_SELECT);
  wire        wr_legacy_a   = wr_stb && addr_hit(addr, `ADDR_LEGACY_A);
  wire        wr_legacy_b   = wr_stb && addr_hit(addr, `ADDR_LEGACY_B);

  //////////////////////////////////////////////////////////////////////////////
  // event latches: one per source, a set in the clearing cycle wins
  reg  [7:0]  event_q;
  wire [7:0]  event_d;
  reg  [7:0]  irq_select_q;
  reg  [23:0] legacy_ec_q;
  reg  [23:0] legacy_ed_q;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_event
      // losing an event to a read clear would hide it from the host
      assign event_d[gi] = event_pulse[gi] | (event_q[gi] & ~rd_events);
    end
  endgenerate

  always @(posedge clk) begin
    if (sys_rst)
      event_q <= 8'h00;
    else
      event_q <= event_d;
  end

  // interrupt source select, written by the host
  always @(posedge clk) begin
    if (sys_rst)
      irq_select_q <= `RST_IRQ_SELECT;
    else if (wr_irq_select)
      irq_select_q <= wr_data[15:8];
  end

  // storage behind the two addresses kept from the older part
  always @(posedge clk) begin
    if (sys_rst) begin
      legacy_ec_q <= `RST_LEGACY;
      legacy_ed_q <= `RST_LEGACY;
    end else begin
      if (wr_legacy_a)
        legacy_ec_q <= wr_data;
      if (wr_legacy_b)
        legacy_ed_q <= wr_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt pin: low level while any selected flag is latched
  // a level only: the host ends it by reading the flags
  wire [7:0] irq_sources;
  wire       irq_any;

  assign irq_sources = event_q & irq_select_q;
  assign irq_any     = |irq_sources;

  always @(posedge clk) begin
    if (sys_rst) begin
      irq_n_q  <= 1'b1;
      irq_oe_q <= 1'b0;
    end else begin
      irq_n_q  <= ~irq_any;
      irq_oe_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read words, assembled field by field
  // first word:  [6:0] input detect, [7] zero, [15:8] event flags,
  //              [19:16] stream indicators, [23:20] zero
  // second word: [3:0] port levels, [7:4] rate code, [23:8] zero
  // event order, low to high: fault, input seen, rate change,
  // channel status renewed, non-linear audio, burst preamble renewed,
  // port event, emphasis
  wire [23:0] word_detect_events;
  wire [23:0] word_port_rate;

  assign word_detect_events[`POS_DETECT +: 7]    = det_sync;
  assign word_detect_events[`POS_DETECT + 7]     = 1'b0;
  assign word_detect_events[`POS_EVENTS +: 8]    = event_q;
  assign word_detect_events[`POS_STREAM +: 4]    = stream_status;
  // no frame-length report exists in this word
  assign word_detect_events[`POS_FRAME_LEN +: 4] = 4'h0;

  assign word_port_rate[`POS_PORT_LEVEL +: 4]    = port_sync;
  assign word_port_rate[`POS_RATE_CODE +: 4]     = computed_rate_code;
  // the old measured-rate byte is gone; keep it quiet
  assign word_port_rate[23:8]                    = 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // read register: loads only on a read, so the host may sample late
  always @(posedge clk) begin
    if (sys_rst) begin
      rd_data_q  <= `RST_WORD;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_stb;
      if (rd_events)
        rd_data_q <= word_detect_events;
      else if (rd_port_rate)
        rd_data_q <= word_port_rate;
      else if (rd_legacy_a)
        rd_data_q <= legacy_ec_q;
      else if (rd_legacy_b)
        rd_data_q <= legacy_ed_q;
      // unmapped addresses, the retired one included, read as zero
      else if (rd_stb)
        rd_data_q <= `RST_WORD;
    end
  end

endmodule
`default_nettype wire

// File: test/status_bank_asserts.sv
// checker: read word fields, strap pins
`timescale 1ns/1ps
`default_nettype none
module status_bank_asserts (input wire logic clk, sys_rst, rd_stb, aux_rx_through_oe_q,
  input wire logic [3:0] stream_status, computed_rate_code, aux_port_pin_oe_q,
  input wire logic [7:0] addr, input wire logic [23:0] rd_data_q);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire ea = rd_stb && addr == 8'hEA, eb = rd_stb && addr == 8'hEB;
  property p_b7; ea |=> !rd_data_q[7]; endproperty
  a_b7: assert property (p_b7) else $error("b7");
  property p_st; ea |=> rd_data_q[19:16] == $past(stream_status); endproperty
  a_st: assert property (p_st) else $error("st");
  property p_fl; ea |=> rd_data_q[23:20] == 4'h0; endproperty
  a_fl: assert property (p_fl) else $error("fl");
  property p_rc; eb |=> rd_data_q[7:4] == $past(computed_rate_code); endproperty
  a_rc: assert property (p_rc) else $error("rc");
  property p_md; eb |=> rd_data_q[23:8] == 16'h0; endproperty
  a_md: assert property (p_md) else $error("md");
  property p_e9; rd_stb && addr == 8'hE9 |=> rd_data_q == 24'h0; endproperty
  a_e9: assert property (p_e9) else $error("e9");
  property p_th; !$past(sys_rst) |-> aux_rx_through_oe_q; endproperty
  a_th: assert property (p_th) else $error("th");
  property p_hd; !$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(aux_port_pin_oe_q);
  endproperty
  a_hd: assert property (p_hd) else $error("hd");
  c_a: cover property (ea);
  c_b: cover property (eb);
  c_c: cover property (rd_stb && addr == 8'hEC);
endmodule
bind receiver_status_readback status_bank_asserts i_chk (.*);
`default_nettype wire

// File: test/host_model.sv
// host: one-cycle read or write strobes
`timescale 1ns/1ps
`default_nettype none
module host_model (input wire logic clk, output logic wr_stb = 0, rd_stb = 0,
  output logic [7:0] addr = 0, output logic [23:0] wr_data = 0);
  task acc(input logic [7:0] a, input logic [23:0] d, input logic w);
    @(negedge clk) {addr, wr_data, wr_stb, rd_stb} = {a, d, w, !w};
    @(negedge clk) {addr, wr_data, wr_stb, rd_stb} = {~a, ~d, 2'b0};
  endtask
endmodule
`default_nettype wire

// File: test/receiver_status_readback_tb_top.sv
// bench: strap, read words, writes, interrupt level
`timescale 1ns/1ps
`default_nettype none
module receiver_status_readback_tb_top;
  logic clk = 0, sys_rst = 1, strap, wr_stb, rd_stb, rd_valid_q, irq_n_q, irq_oe_q;
  logic aux_rx_through_oe_q;
  logic [3:0] stream_status, computed_rate_code, aux_port_pin_in, aux_port_pin_oe_q;
  logic [6:0] input_present_flag;
  logic [7:0] addr, e, event_pulse = 0;
  logic [23:0] wr_data, rd_data_q;
  // the pull resistor wins while the pin is released or not yet set up
  wire irq_pin_in = (irq_oe_q === 1'b1) ? irq_n_q : strap;
  int seed = 71988, mismatches = 0, n_checks = 0, k;
  always #2.5 clk = ~clk;
  host_model i_host_model (.*);
  receiver_status_readback i_receiver_status_readback (.*);
  task chk(input logic [23:0] g, x);
    n_checks++;
    if (g !== x) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task rd(input logic [7:0] a, input logic [23:0] x);
    i_host_model.acc(a, 0, 0);
    chk((rd_valid_q === 1'b1) ? rd_data_q : ~x, x);
  endtask
  function logic [23:0] wa(input logic [7:0] v);
    return {4'h0, stream_status, v, 1'b0, input_present_flag};
  endfunction
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial #50000 begin
    mismatches++;
    print_verdict;
  end
  initial begin
    {input_present_flag, stream_status, computed_rate_code, aux_port_pin_in} = 0;
    for (k = 1; k >= 0; k--) begin
      {sys_rst, strap} = {1'b1, k[0]};
      // mid-run the pin is still driven until the first reset edge
      repeat (k ? 3 : 4) @(negedge clk);
      sys_rst = 0;
      @(negedge clk);
      chk({aux_port_pin_oe_q, aux_rx_through_oe_q}, {{4{k[0]}}, 1'b1});
    end
    $display("strap done");
    for (k = 0; k < 8; k++) begin
      e = k ? 8'($random(seed)) : 8'hFF;
      {input_present_flag, stream_status, computed_rate_code, aux_port_pin_in} = 19'($random(seed));
      event_pulse = e;
      @(negedge clk) event_pulse = 0;
      repeat (2) @(negedge clk);
      rd(8'hEA, wa(e));
      rd(8'hEA, wa(0));
      rd(8'hEB, {16'h0, computed_rate_code, aux_port_pin_in});
    end
    $display("read words done");
    i_host_model.acc(8'hE9, 24'hA5A5A5, 1);
    rd(8'hE9, 0);
    i_host_model.acc(8'hEC, 24'h5A5A5A, 1);
    rd(8'hEC, 24'h5A5A5A);
    i_host_model.acc(8'hED, 24'h3C3C3C, 1);
    rd(8'hED, 24'h3C3C3C);
    i_host_model.acc(8'h08, 24'h8000, 1);
    event_pulse = 8'h80;
    @(negedge clk) event_pulse = 0;
    repeat (3) @(negedge clk);
    chk(irq_n_q, 0);
    rd(8'hEA, wa(8'h80));
    @(negedge clk) chk(irq_n_q, 1);
    $display("irq done");
    print_verdict;
  end
endmodule
`default_nettype wire
